// ### cdrlc_pkg.sv
// How it works
// - auto mode keeps data lock while ppm difference is below threshold
// - auto mode falls back to reference lock when ppm difference exceeds threshold
// - threshold code selects 62.5 to 1000 ppm in 62.5 ppm steps
// - force-reference input high makes the recovery unit lock to reference clock
// - force-data input high makes the recovery unit lock to received data
// - both force inputs high: data lock wins
// - both force inputs low: automatic mode from ppm comparison
// - reference-locked output high once locked to reference; meaningless in data lock
// - data-lock-achieved high after auto switch from reference to data lock
// - receiver analog reset exists only with receiver, held two parallel clocks minimum
// - receiver digital reset exists only with receiver, held two clocks minimum
// - transmitter digital reset exists only with transmitter, held two clocks minimum
// - block power-down powers down all channels and both PLLs
// - two transmit PLLs, each with its own power-down
// - each transmit PLL drives its own lock-status output
// - training option makes recovery unit train from the transmit PLL reference clock
// - base rate above effective rate enables the receiver local clock divider
// - PCI Express mode fixes reference clock at 100 MHz
// - single-lane gen1 PCI Express base rate selectable 2500 or 5000 Mbps
// - transmit PLL and recovery unit bandwidth: auto, low, medium, high
// - PLL feedback path only in deterministic-latency mode
package cdrlc_pkg;
   localparam int NUM_PLL = 2;
   localparam int PPM_W = 12;
   localparam int THR_CODE_W = 4;
   // ppm values are in half-ppm units
   localparam logic [PPM_W-1:0] PPM_STEP_HALF = 12'h07D;
   localparam logic [PPM_W-1:0] PPM_THR_MIN = 12'h07D;
   localparam logic [PPM_W-1:0] PPM_THR_MAX = 12'h7D0;
   localparam int RST_NUM = 3;
   localparam logic [1:0] RST_CNT_LOAD = 2'h1;
   localparam int RST_RX_ANA = 0;
   localparam int RST_RX_DIG = 1;
   localparam int RST_TX_DIG = 2;
   localparam int RATE_W = 13;
   localparam logic [RATE_W-1:0] PCIE_RATE_LO = 13'h09C4;
   localparam logic [RATE_W-1:0] PCIE_RATE_HI = 13'h1388;
   localparam int REFCLK_W = 10;
   localparam logic [REFCLK_W-1:0] PCIE_REFCLK_MHZ = 10'h064;

   typedef enum logic [1:0] {BW_AUTO, BW_LOW, BW_MEDIUM, BW_HIGH} cdrlc_bw_t;
   typedef enum logic [1:0] {MODE_BASIC, MODE_DETLAT, MODE_PCIE, MODE_OTHER} cdrlc_mode_t;
   typedef enum logic [1:0] {CDR_OFF, CDR_REF, CDR_DATA} cdrlc_cdr_st_t;

   typedef struct packed {
      logic force_ref;
      logic force_data;
      logic rx_ana_rst;
      logic rx_dig_rst;
      logic tx_dig_rst;
      logic blk_pd;
      logic [NUM_PLL-1:0] pll_pd;
   } cdrlc_ctrl_t;

   typedef struct packed {
      logic lock_to_data;
      logic auto_mode;
      logic ref_locked;
      logic data_locked;
   } cdrlc_lock_t;

   typedef struct packed {
      logic rx_ana;
      logic rx_dig;
      logic tx_dig;
   } cdrlc_rst_t;

   typedef struct packed {
      logic blk_pd;
      logic [NUM_PLL-1:0] pd;
      logic [NUM_PLL-1:0] locked;
   } cdrlc_pll_t;

   typedef struct packed {
      cdrlc_mode_t mode;
      logic pcie_gen1x1;
      logic base_hi;
      logic train_from_pll;
      logic pfd_fb_req;
      cdrlc_bw_t tx_bw;
      cdrlc_bw_t cdr_bw;
      logic [THR_CODE_W-1:0] thr_code;
      logic [REFCLK_W-1:0] refclk_mhz;
      logic [RATE_W-1:0] base_rate;
      logic [RATE_W-1:0] eff_rate;
   } cdrlc_cfg_t;

   typedef struct packed {
      logic cdr_ref_from_pll;
      logic local_div_en;
      logic pfd_fb_en;
      cdrlc_bw_t tx_bw;
      cdrlc_bw_t cdr_bw;
      logic [REFCLK_W-1:0] refclk_mhz;
      logic [RATE_W-1:0] base_rate;
   } cdrlc_cfg_out_t;
endpackage : cdrlc_pkg

// ### cdrlc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cdrlc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } cdrlc_sync_state_t;

   cdrlc_sync_state_t st_q;
   cdrlc_sync_state_t st_d;

   // first stage feeds only the second
   always_comb begin
      st_d.s1 = i_d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_q = st_q.s2;
endmodule : cdrlc_sync
`default_nettype wire

// ### cdrlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module cdrlc_top
   import cdrlc_pkg::*;
#(
   parameter bit HAS_RX = 1'b1,
   parameter bit HAS_TX = 1'b1
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // fabric controls, asynchronous to the parallel clock
   input wire cdrlc_ctrl_t i_ctrl,
   // static configuration
   input wire cdrlc_cfg_t i_cfg,
   // analog status
   input wire logic [PPM_W-1:0] i_ppm_diff,
   input wire logic i_ref_lock_det,
   input wire logic [NUM_PLL-1:0] i_pll_lock_det,
   // lock status and mode
   output cdrlc_lock_t o_lock,
   // resets to the channel
   output cdrlc_rst_t o_rst,
   // PLL and block power state
   output cdrlc_pll_t o_pll,
   // derived configuration
   output cdrlc_cfg_out_t o_cfg
);
   typedef struct packed {
      cdrlc_cdr_st_t cdr;
      cdrlc_lock_t lock;
      cdrlc_rst_t rst;
      logic [RST_NUM-1:0][1:0] rst_cnt;
      cdrlc_pll_t pll;
      cdrlc_cfg_out_t cfg;
   } cdrlc_top_state_t;

   cdrlc_top_state_t q;
   cdrlc_top_state_t d;
   cdrlc_ctrl_t c;
   logic [PPM_W-1:0] thr;
   logic ppm_over;
   logic ppm_under;
   logic auto_sel;
   logic ana_rst_act;
   logic [RST_NUM-1:0] rst_req;
   logic [RST_NUM-1:0] rst_out;

   cdrlc_sync #(
      .W($bits(cdrlc_ctrl_t))
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_d(i_ctrl),
      .o_q(c)
   );

   // threshold in half-ppm: (code + 1) * 62.5 ppm
   assign thr = PPM_W'((PPM_W'(i_cfg.thr_code) + PPM_W'(1)) * PPM_STEP_HALF);
   assign ppm_over = i_ppm_diff > thr;
   assign ppm_under = i_ppm_diff < thr;
   assign auto_sel = !c.force_ref && !c.force_data;
   assign ana_rst_act = q.rst.rx_ana;

   always_comb begin
      d = q;
      rst_req = '0;
      rst_out = '0;

      // lock-mode selection; power-down and analog reset park the loop
      if (c.blk_pd) begin
         d.cdr = CDR_OFF;
      end else if (ana_rst_act) begin
         d.cdr = CDR_REF;
      end else if (c.force_data) begin
         d.cdr = CDR_DATA;
      end else if (c.force_ref) begin
         d.cdr = CDR_REF;
      end else begin
         case (q.cdr)
            CDR_OFF: begin
               d.cdr = CDR_REF;
            end
            CDR_REF: begin
               if (i_ref_lock_det && ppm_under) begin
                  d.cdr = CDR_DATA;
               end
            end
            CDR_DATA: begin
               if (ppm_over) begin
                  d.cdr = CDR_REF;
               end else begin
                  d.cdr = CDR_DATA;
               end
            end
            default: begin
               d.cdr = CDR_OFF;
            end
         endcase
      end

      d.lock.lock_to_data = (d.cdr == CDR_DATA);
      d.lock.auto_mode = auto_sel && !c.blk_pd;
      // only valid while the loop stays on the reference
      d.lock.ref_locked = (d.cdr == CDR_REF) && (q.cdr == CDR_REF) && i_ref_lock_det;
      d.lock.data_locked = auto_sel && (d.cdr == CDR_DATA)
                           && (q.lock.data_locked || q.cdr == CDR_REF);

      // resets stretched so each pulse lasts at least two clocks
      rst_req[RST_RX_ANA] = HAS_RX && (c.rx_ana_rst || c.blk_pd);
      rst_req[RST_RX_DIG] = HAS_RX && (c.rx_dig_rst || c.blk_pd);
      rst_req[RST_TX_DIG] = HAS_TX && (c.tx_dig_rst || c.blk_pd);
      for (int i = 0; i < RST_NUM; i++) begin
         if (rst_req[i]) begin
            d.rst_cnt[i] = RST_CNT_LOAD;
         end else if (q.rst_cnt[i] != 2'h0) begin
            d.rst_cnt[i] = q.rst_cnt[i] - 2'h1;
         end else begin
            d.rst_cnt[i] = 2'h0;
         end
         rst_out[i] = rst_req[i] || (q.rst_cnt[i] != 2'h0);
      end
      d.rst.rx_ana = rst_out[RST_RX_ANA];
      d.rst.rx_dig = rst_out[RST_RX_DIG];
      d.rst.tx_dig = rst_out[RST_TX_DIG];

      // per-PLL power-down and lock status
      d.pll.blk_pd = c.blk_pd;
      for (int i = 0; i < NUM_PLL; i++) begin
         d.pll.pd[i] = c.blk_pd || c.pll_pd[i];
         d.pll.locked[i] = i_pll_lock_det[i] && !d.pll.pd[i];
      end

      // derived configuration
      d.cfg.cdr_ref_from_pll = i_cfg.train_from_pll;
      d.cfg.tx_bw = i_cfg.tx_bw;
      d.cfg.cdr_bw = i_cfg.cdr_bw;
      d.cfg.pfd_fb_en = i_cfg.pfd_fb_req && (i_cfg.mode == MODE_DETLAT);
      if (i_cfg.mode == MODE_PCIE) begin
         d.cfg.refclk_mhz = PCIE_REFCLK_MHZ;
      end else begin
         d.cfg.refclk_mhz = i_cfg.refclk_mhz;
      end
      if (i_cfg.mode == MODE_PCIE && i_cfg.pcie_gen1x1) begin
         d.cfg.base_rate = i_cfg.base_hi ? PCIE_RATE_HI : PCIE_RATE_LO;
      end else begin
         d.cfg.base_rate = i_cfg.base_rate;
      end
      d.cfg.local_div_en = d.cfg.base_rate > i_cfg.eff_rate;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_lock = q.lock;
   assign o_rst = q.rst;
   assign o_pll = q.pll;
   assign o_cfg = q.cfg;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   a_auto_stay_data: assert property (
      (auto_sel && !c.blk_pd && !ana_rst_act && q.cdr == CDR_DATA && !ppm_over)
      |=> o_lock.lock_to_data)
      else $error("auto mode left data lock below threshold");

   a_auto_fall_back: assert property (
      (auto_sel && !c.blk_pd && q.cdr == CDR_DATA && ppm_over)
      |=> !o_lock.lock_to_data)
      else $error("auto mode stayed in data lock above threshold");

   a_thr_in_range: assert property (
      thr >= PPM_THR_MIN && thr <= PPM_THR_MAX && thr == PPM_W'((i_cfg.thr_code + 1) * PPM_STEP_HALF))
      else $error("ppm threshold out of range");

   a_force_ref_lock: assert property (
      (c.force_ref && !c.force_data && !c.blk_pd) |=> (q.cdr == CDR_REF))
      else $error("force reference did not select reference lock");

   a_force_data_wins: assert property (
      (c.force_data && c.force_ref && !c.blk_pd && !ana_rst_act) |=> o_lock.lock_to_data)
      else $error("force data did not win over force reference");

   a_auto_flag: assert property (
      (!c.force_ref && !c.force_data && !c.blk_pd) |=> o_lock.auto_mode)
      else $error("auto flag low with both force inputs low");

   a_ref_locked_only: assert property (
      o_lock.ref_locked |-> !o_lock.lock_to_data && $past(q.cdr) == CDR_REF)
      else $error("reference locked shown outside reference lock");

   a_data_lock_auto: assert property (
      $rose(o_lock.data_locked) |-> o_lock.auto_mode && $past(q.cdr) == CDR_REF)
      else $error("data lock achieved without auto switch");

   a_rx_ana_width: assert property (
      $rose(o_rst.rx_ana) |=> o_rst.rx_ana)
      else $error("receiver analog reset shorter than two clocks");

   a_rx_dig_width: assert property (
      $rose(o_rst.rx_dig) |=> o_rst.rx_dig)
      else $error("receiver digital reset shorter than two clocks");

   a_tx_dig_width: assert property (
      $rose(o_rst.tx_dig) |=> o_rst.tx_dig)
      else $error("transmitter digital reset shorter than two clocks");

   a_blk_pd_all: assert property (
      c.blk_pd |=> (&o_pll.pd) && !o_lock.lock_to_data && o_pll.locked == '0)
      else $error("block power-down left a PLL or channel active");

   a_pll_lock_gated: assert property (
      (o_pll.locked & o_pll.pd) == '0)
      else $error("powered-down PLL reports lock");

   a_pcie_refclk: assert property (
      (i_cfg.mode == MODE_PCIE) |=> o_cfg.refclk_mhz == PCIE_REFCLK_MHZ)
      else $error("pcie reference clock not fixed");

   a_pfd_detlat: assert property (
      o_cfg.pfd_fb_en |-> $past(i_cfg.mode) == MODE_DETLAT)
      else $error("feedback path outside deterministic latency");

   a_sync_delay: assert property (
      (!i_ctrl.blk_pd [*3] ##1 i_ctrl.blk_pd) |-> !o_pll.blk_pd [*3])
      else $error("power-down acted before synchronisation");

   a_force_data_lock: assert property (
      (c.force_data && !c.blk_pd && !ana_rst_act) |=> o_lock.lock_to_data && !o_lock.auto_mode)
      else $error("force data did not select data lock");

   a_force_clears_flag: assert property (
      (c.force_ref || c.force_data) |=> !o_lock.data_locked)
      else $error("data lock achieved shown while forced");

   a_auto_to_data: assert property (
      (auto_sel && !c.blk_pd && !ana_rst_act && q.cdr == CDR_REF && i_ref_lock_det && ppm_under)
      |=> o_lock.lock_to_data && o_lock.data_locked)
      else $error("auto mode did not move to data lock below threshold");

   a_auto_hold_ref: assert property (
      (auto_sel && !c.blk_pd && q.cdr == CDR_REF && !ppm_under) |=> !o_lock.lock_to_data)
      else $error("auto mode left reference lock at or above threshold");

   a_ref_lock_flag: assert property (
      (c.force_ref && !c.force_data && !c.blk_pd && q.cdr == CDR_REF && i_ref_lock_det) |=> o_lock.ref_locked)
      else $error("reference locked missing in reference lock");

   a_data_flag_mode: assert property (
      o_lock.data_locked |-> o_lock.lock_to_data && o_lock.auto_mode)
      else $error("data lock achieved outside automatic data lock");

   a_blk_pd_resets: assert property (
      c.blk_pd |=> o_rst.rx_ana == HAS_RX && o_rst.rx_dig == HAS_RX && o_rst.tx_dig == HAS_TX)
      else $error("block power-down left a reset released");

   a_blk_pd_flag: assert property (
      c.blk_pd |=> o_pll.blk_pd && !o_lock.auto_mode && !o_lock.data_locked)
      else $error("block power-down flag or lock state wrong");

   a_pll_pd_own: assert property (
      !c.blk_pd |=> o_pll.pd == $past(c.pll_pd))
      else $error("pll power-down not per pll");

   a_pll_lock_follow: assert property (
      1'b1 |=> o_pll.locked == ($past(i_pll_lock_det) & ~o_pll.pd))
      else $error("pll lock status does not follow its detector");

   a_cfg_train: assert property (
      1'b1 |=> o_cfg.cdr_ref_from_pll == $past(i_cfg.train_from_pll))
      else $error("training source does not follow its setting");

   a_local_div: assert property (
      (i_cfg.mode != MODE_PCIE) |=> o_cfg.local_div_en == ($past(i_cfg.base_rate) > $past(i_cfg.eff_rate)))
      else $error("local divider enable wrong");

   a_pcie_base: assert property (
      (i_cfg.mode == MODE_PCIE && i_cfg.pcie_gen1x1)
      |=> (o_cfg.base_rate == PCIE_RATE_LO || o_cfg.base_rate == PCIE_RATE_HI))
      else $error("pcie base rate not one of the two choices");

   a_bw_pass: assert property (
      1'b1 |=> o_cfg.tx_bw == $past(i_cfg.tx_bw) && o_cfg.cdr_bw == $past(i_cfg.cdr_bw))
      else $error("bandwidth setting not passed on");

   a_rx_dig_req: assert property (
      c.rx_dig_rst |=> o_rst.rx_dig == HAS_RX)
      else $error("receiver digital reset request not applied");

   a_ana_rst_ref: assert property (
      (ana_rst_act && !c.blk_pd) |=> !o_lock.lock_to_data && !o_lock.data_locked)
      else $error("analog reset did not park the loop on the reference");

   a_pfd_off: assert property (
      (i_cfg.mode != MODE_DETLAT) |=> !o_cfg.pfd_fb_en)
      else $error("feedback path enabled outside deterministic latency");

   c_auto_to_data: cover property (auto_sel && q.cdr == CDR_REF ##1 o_lock.data_locked);
   c_auto_fallback: cover property (o_lock.data_locked ##1 !o_lock.lock_to_data);
   c_both_forced: cover property (c.force_ref && c.force_data ##1 o_lock.lock_to_data);
   c_blk_pd: cover property ($rose(o_pll.blk_pd));
   c_forced_ref: cover property (c.force_ref && !c.force_data ##2 o_lock.ref_locked);
endmodule : cdrlc_top
`default_nettype wire

// ### cdrlc_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdrlc_fabric_model
   import cdrlc_pkg::*;
(
   // clock
   input wire logic i_mclk,
   // requests from the test sequence
   input wire cdrlc_ctrl_t i_req,
   // controls to the block
   output var cdrlc_ctrl_t o_ctrl
);
   logic [2:0] hold_q;

   initial begin
      o_ctrl = '0;
      hold_q = 3'h0;
   end

   // reset requests stretched to two parallel clocks at least
   always @(negedge i_mclk) begin
      hold_q <= {i_req.rx_ana_rst, i_req.rx_dig_rst, i_req.tx_dig_rst};
      o_ctrl <= i_req;
      o_ctrl.rx_ana_rst <= i_req.rx_ana_rst | hold_q[2];
      o_ctrl.rx_dig_rst <= i_req.rx_dig_rst | hold_q[1];
      o_ctrl.tx_dig_rst <= i_req.tx_dig_rst | hold_q[0];
   end
endmodule : cdrlc_fabric_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cdrlc_pkg::*;
;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   cdrlc_ctrl_t req = '0;
   cdrlc_ctrl_t ctrl;
   cdrlc_cfg_t cfg;
   logic [PPM_W-1:0] ppm;
   logic ref_det;
   logic [NUM_PLL-1:0] pll_det;
   cdrlc_lock_t lk;
   cdrlc_rst_t rs;
   cdrlc_pll_t pl;
   cdrlc_cfg_out_t co;
   int err_count = 0;
   int n_checks = 0;
   logic [2:0] v;

   always #20 mclk = ~mclk;

   cdrlc_fabric_model fab_u (.i_mclk(mclk), .i_req(req), .o_ctrl(ctrl));

   cdrlc_top dut_u (.i_mclk(mclk), .i_rstn(rstn), .i_ctrl(ctrl), .i_cfg(cfg), .i_ppm_diff(ppm),
      .i_ref_lock_det(ref_det), .i_pll_lock_det(pll_det), .o_lock(lk), .o_rst(rs), .o_pll(pl), .o_cfg(co));

   task step(input int n);
      repeat (n) @(negedge mclk);
   endtask : step

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   initial begin
      #(40 * 4000);
      err_count++;
      $display("ERROR watchdog expected done seen timeout");
      stop_test();
   end

   initial begin
      cfg = '0;
      cfg.base_rate = PCIE_RATE_LO;
      cfg.eff_rate = PCIE_RATE_LO;
      ppm = 12'h064;
      ref_det = 1'b1;
      pll_det = 2'h0;
      step(5);
      rstn = 1'b1;
      // automatic switching around the threshold, edges included
      step(5);
      chk("auto data", {lk.lock_to_data, lk.auto_mode, lk.data_locked}, 3'h7);
      ppm = 12'h07D;
      step(3);
      chk("equal thr", lk.lock_to_data, 1'b1);
      ppm = 12'h07E;
      step(3);
      chk("above thr", {lk.lock_to_data, lk.data_locked}, 2'h0);
      chk("ref locked", lk.ref_locked, 1'b1);
      cfg.thr_code = 4'hF;
      ppm = 12'h7CF;
      step(3);
      chk("max thr below", lk.lock_to_data, 1'b1);
      ppm = 12'h7D1;
      step(3);
      chk("max thr above", lk.lock_to_data, 1'b0);
      $display("test auto done");
      // forcing and precedence
      req.force_data <= 1'b1;
      step(5);
      chk("force data", {lk.lock_to_data, lk.auto_mode, lk.data_locked}, 3'h4);
      req.force_ref <= 1'b1;
      step(5);
      chk("both forces", {lk.lock_to_data, lk.auto_mode, lk.data_locked}, 3'h4);
      req.force_data <= 1'b0;
      ppm = 12'h010;
      step(5);
      chk("force ref", {lk.lock_to_data, lk.auto_mode, lk.data_locked}, 3'h0);
      chk("force ref locked", lk.ref_locked, 1'b1);
      req.force_ref <= 1'b0;
      step(5);
      chk("back to auto", {lk.lock_to_data, lk.auto_mode, lk.data_locked}, 3'h7);
      chk("data achieved", lk.data_locked, 1'b1);
      $display("test force done");
      // one-cycle requests, stretched by the fabric model
      for (int i = 0; i < 3; i++) begin
         v = 3'h4 >> i;
         req.rx_ana_rst <= v[2];
         req.rx_dig_rst <= v[1];
         req.tx_dig_rst <= v[0];
         step(1);
         req.rx_ana_rst <= 1'b0;
         req.rx_dig_rst <= 1'b0;
         req.tx_dig_rst <= 1'b0;
         step(4);
         chk("reset on", rs, v);
         step(6);
         chk("reset off", rs, 3'h0);
      end
      $display("test resets done");
      // power-down and PLL lock reporting
      pll_det = 2'h3;
      req.pll_pd <= 2'h1;
      step(5);
      chk("pll0 down", {pl.blk_pd, pl.pd, pl.locked}, 5'h06);
      req.pll_pd <= 2'h2;
      step(5);
      chk("pll1 down", {pl.blk_pd, pl.pd, pl.locked}, 5'h09);
      req.pll_pd <= 2'h0;
      req.blk_pd <= 1'b1;
      step(5);
      chk("block down", {pl.blk_pd, pl.pd, pl.locked}, 5'h1C);
      chk("block resets", rs, 3'h7);
      req.blk_pd <= 1'b0;
      pll_det = 2'h1;
      step(6);
      chk("pll lock", pl.locked, 2'h1);
      $display("test power done");
      // derived configuration
      cfg.mode = MODE_PCIE;
      cfg.refclk_mhz = 10'h07B;
      cfg.pcie_gen1x1 = 1'b1;
      cfg.base_hi = 1'b1;
      step(2);
      chk("pcie refclk", co.refclk_mhz, PCIE_REFCLK_MHZ);
      chk("no train", co.cdr_ref_from_pll, 1'b0);
      chk("base hi", co.base_rate, PCIE_RATE_HI);
      chk("divider on", co.local_div_en, 1'b1);
      cfg.base_hi = 1'b0;
      step(2);
      chk("base lo", co.base_rate, PCIE_RATE_LO);
      chk("divider off", co.local_div_en, 1'b0);
      cfg.mode = MODE_DETLAT;
      cfg.pfd_fb_req = 1'b1;
      cfg.train_from_pll = 1'b1;
      step(2);
      chk("feedback on", co.pfd_fb_en, 1'b1);
      chk("user refclk", co.refclk_mhz, 10'h07B);
      chk("train", co.cdr_ref_from_pll, 1'b1);
      cfg.mode = MODE_BASIC;
      step(2);
      chk("feedback off", co.pfd_fb_en, 1'b0);
      for (int b = 0; b < 4; b++) begin
         cfg.tx_bw = cdrlc_bw_t'(b);
         cfg.cdr_bw = cdrlc_bw_t'(3 - b);
         step(2);
         chk("bandwidth", {co.tx_bw, co.cdr_bw}, {2'(b), 2'(3 - b)});
      end
      $display("test config done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
